// file: hdl/bcs_pkg.sv
// Constants for the bit counted serial shifter
package bcs_pkg;
	localparam logic [7:0] BCS_DATA_ADDR = 8'hdd;
	localparam logic [7:0] BCS_IDIS_ADDR = 8'hc2;
	localparam logic [7:0] BCS_DATA_RESET = 8'h00;
	localparam logic [3:0] BCS_CNT_RESET = 4'h0;
	localparam logic [3:0] BCS_CNT_TERM = 4'h8;
	localparam int BCS_MSB = 7;
endpackage

// file: hdl/bcs_shifter.sv
// Bit counted serial shifter with eight pulse interrupt
//
// Behaviour
// - Eight bit shift register and four bit pulse counter.
// - Shifts most significant bit first, in from serial input, out to serial output.
// - Register and counter advance on each falling shift clock edge up to the eighth, except in a cycle with a data write.
// - After eight pulses terminal output goes low and gates clocking off.
// - Interrupt on eighth falling edge unless a write reset the counter first.
// - After reset the interrupt stays disabled until re-armed.
// - Data write arms interrupt; disable register write disarms it.
// - Interrupt request is a high to low transition.
// - Reset or data write clears counter and re-enables clocking.
// - No start condition detection; edges are accepted directly.
// - Any write to disable register address disarms; value ignored.
// - Data register at own address, read write, re-arms on write.
// - Open drain select connects shift output to pin regardless of use.
`timescale 1ns/10ps
`default_nettype none
module bcs_shifter
	import bcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	input wire logic sclk_in,
	input wire logic sin_in,
	input wire logic sout_open_drain,
	output logic sout_out,
	output logic sout_oe,
	output logic irq_b,
	output logic counter_terminal_out
);
	// ==================================================
	// Pin synchronisers
	logic [1:0] sclk_sync_reg;
	logic [1:0] sin_sync_reg;
	logic sclk_prev_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_sync_reg <= 2'h3;
			sin_sync_reg <= 2'h3;
			sclk_prev_reg <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
			sin_sync_reg <= {sin_sync_reg[0], sin_in};
			sclk_prev_reg <= sclk_sync_reg[1];
		end
	end

	// ==================================================
	// Address decode helper
	// One compare shared by the write and read decodes keeps them in step
	function automatic logic bcs_addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		return addr == reg_addr;
	endfunction

	// ==================================================
	// Decode and shift datapath
	logic [7:0] data_shift_register;
	logic [3:0] count_reg;
	logic arm_reg;
	logic irq_b_reg;
	wire sclk_fall = sclk_prev_reg & ~sclk_sync_reg[1];
	// The edge detector costs three cycles of latency, so the pin phases need two or more
	wire data_wr = cpu_wr & bcs_addr_hit(cpu_addr, BCS_DATA_ADDR);
	// Value on the data bus is not used here
	wire idis_wr = cpu_wr & bcs_addr_hit(cpu_addr, BCS_IDIS_ADDR);
	assign counter_terminal_out = (count_reg != BCS_CNT_TERM);
	wire shift_en = sclk_fall & counter_terminal_out & ~data_wr;
	wire last_edge = shift_en & (count_reg == BCS_CNT_TERM - 4'h1);
	// msb first, sample on same edge
	wire [7:0] shift_next = {data_shift_register[BCS_MSB-1:0], sin_sync_reg[1]};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_shift_register <= BCS_DATA_RESET;
			count_reg <= BCS_CNT_RESET;
		end else if (data_wr) begin
			data_shift_register <= cpu_wdata;
			count_reg <= BCS_CNT_RESET;
		end else if (shift_en) begin
			data_shift_register <= shift_next;
			count_reg <= count_reg + 4'h1;
		end
	end

	// ==================================================
	// Interrupt arming and request
	// A write beats a shift edge in the same cycle, so no half byte is counted
	// arm and disarm
	// falling interrupt, held low until write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arm_reg <= 1'b0;
			irq_b_reg <= 1'b1;
		end else begin
			if (data_wr) begin
				arm_reg <= 1'b1;
			end else if (idis_wr) begin
				arm_reg <= 1'b0;
			end
			if (data_wr | idis_wr) begin
				irq_b_reg <= 1'b1;
			end else if (last_edge & arm_reg) begin
				irq_b_reg <= 1'b0;
			end
		end
	end
	assign irq_b = irq_b_reg;

	// ==================================================
	// Pin outputs and read path
	// The pin is only ever pulled low; a high level comes from the external pull-up
	// open drain output path, drives only a low
	assign sout_out = 1'b0;
	assign sout_oe = sout_open_drain & ~data_shift_register[BCS_MSB];
	// Read path for the data register; disable register reads zero
	assign cpu_rdata = (cpu_rd & bcs_addr_hit(cpu_addr, BCS_DATA_ADDR)) ? data_shift_register : 8'h00;

	// ==================================================
	// Checks
	AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
		(!counter_terminal_out && !data_wr) |=> $stable(data_shift_register))
		else $error("Register changed while counter stopped");
	AST_EIGHT_STOP: assert property (@(posedge clk) disable iff (!rst_b)
		last_edge |=> !counter_terminal_out)
		else $error("Counter did not stop after eight edges");
	AST_WR_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
		data_wr |=> (count_reg == 4'h0) && (data_shift_register == $past(cpu_wdata)))
		else $error("Write did not reload register and counter");
	AST_IRQ_FALL: assert property (@(posedge clk) disable iff (!rst_b)
		(last_edge && arm_reg && !idis_wr) |=> !irq_b)
		else $error("Interrupt missing on eighth edge");
	AST_DISARM: assert property (@(posedge clk) disable iff (!rst_b)
		idis_wr && !data_wr |=> !arm_reg && irq_b)
		else $error("Disable write did not disarm");
	AST_NO_IRQ_UNARMED: assert property (@(posedge clk) disable iff (!rst_b)
		(!arm_reg && irq_b) |=> irq_b)
		else $error("Interrupt while disarmed");
	AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
		shift_en |=> data_shift_register[BCS_MSB:1] == $past(data_shift_register[6:0]))
		else $error("Shift direction wrong");
	AST_SAMPLE_IN: assert property (@(posedge clk) disable iff (!rst_b)
		shift_en |=> data_shift_register[0] == $past(sin_sync_reg[1]))
		else $error("Input bit not sampled on edge");
	AST_ARM_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		data_wr |=> arm_reg && irq_b)
		else $error("Write did not arm interrupt");

	AST_IRQ_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
		(!irq_b && !data_wr && !idis_wr) |=> !irq_b)
		else $error("Interrupt request released without a write");
	AST_IRQ_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(irq_b) |-> $past(last_edge) && $past(arm_reg))
		else $error("Interrupt fell without a completed byte");
	AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_b)
		shift_en |=> count_reg == $past(count_reg) + 4'h1)
		else $error("Counter did not advance on edge");
	AST_HOLD_NO_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
		(!sclk_fall && !data_wr) |=> $stable(count_reg))
		else $error("Counter moved without an edge");
	AST_NO_SECOND_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
		(!counter_terminal_out && !data_wr && !idis_wr) |=> $stable(irq_b))
		else $error("Interrupt changed while counter stopped");
	AST_TERM_AFTER_WR: assert property (@(posedge clk) disable iff (!rst_b)
		data_wr |=> counter_terminal_out)
		else $error("Write did not re-enable clocking");

	// Scenarios worth seeing
	COV_BYTE: cover property (@(posedge clk) disable iff (!rst_b) last_edge && arm_reg);
	COV_REWRITE: cover property (@(posedge clk) disable iff (!rst_b) data_wr && count_reg == 4'h4);
	COV_DISARM: cover property (@(posedge clk) disable iff (!rst_b) idis_wr && arm_reg);
	COV_QUIET_BYTE: cover property (@(posedge clk) disable iff (!rst_b) last_edge && !arm_reg);
	COV_EXTRA_EDGE: cover property (@(posedge clk) disable iff (!rst_b)
		sclk_fall && !counter_terminal_out);
endmodule
`default_nettype wire

// file: test/bcs_peer.sv
// Serial peer that clocks bytes through the shifter
`timescale 1ns/10ps
`default_nettype none
module bcs_peer (
	input wire logic clk,
	input wire logic line_in,
	output logic sclk,
	output logic sin
);
	initial begin
		sclk = 1'b1;
		sin = 1'b0;
	end
	// clock held between frames
	// Data moves in the high phase so it is stable around each fall
	task automatic xfer(input logic [7:0] tx, input int n, inout logic [7:0] rx);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) sin <= tx[7 - (i % 8)];
			repeat (4) @(posedge clk);
			rx = {rx[6:0], line_in};
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
		end
		// Released line must not keep its last level
		@(posedge clk) sin <= ~sin;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the serial shifter
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import bcs_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, od = 1'b1;
	logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata, tx, px, rx;
	logic sout_out, sout_oe, irq_b, ct, sclk, sin;
	logic [31:0] seed = 32'd87349;
	int errors = 0, compares = 0, n;
	wire logic line = ~sout_oe | sout_out;
	bcs_shifter dut (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .sclk_in(sclk),
		.sin_in(sin), .sout_open_drain(od), .sout_out(sout_out), .sout_oe(sout_oe),
		.irq_b(irq_b), .counter_terminal_out(ct));
	bcs_peer peer (.clk(clk), .line_in(line), .sclk(sclk), .sin(sin));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Register after n edges: old bits move up, peer bits enter below
	function automatic logic [7:0] shifted(input logic [7:0] d, input logic [7:0] p, input int k);
		logic [15:0] w;
		w = {d, p} << ((k > 8) ? 8 : k);
		return w[15:8];
	endfunction
	task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge clk) cpu_wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd_ck(input logic [7:0] e);
		@(posedge clk);
		cpu_addr <= BCS_DATA_ADDR;
		cpu_rd <= 1'b1;
		@(negedge clk) ck("readback", e, cpu_rdata);
		@(posedge clk) cpu_rd <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial forever #25 clk = ~clk;
	// Bound well above the roughly one thousand cycles the sequence needs
	initial begin
		#1000000;
		errors++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rx = 8'h00;
		peer.xfer(8'ha5, 8, rx);
		@(negedge clk);
		ck("irq_b", 8'h01, {7'h00, irq_b});
		ck("terminal", 8'h00, {7'h00, ct});
		rd_ck(8'ha5);
		for (int i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			tx = seed[7:0];
			px = seed[15:8];
			n = (i < 3) ? 7 + i : 3 + int'(seed[18:16]);
			od <= (i < 3) | seed[20];
			wr(BCS_DATA_ADDR, tx);
			ck("terminal", 8'h01, {7'h00, ct});
			ck("oe", {7'h00, od & ~tx[7]}, {7'h00, sout_oe});
			peer.xfer(px, n, rx);
			ck("irq_b", {7'h00, n < 8}, {7'h00, irq_b});
			ck("terminal", {7'h00, n < 8}, {7'h00, ct});
			rd_ck(shifted(tx, px, n));
			if (n == 8 && od) ck("line", tx, rx);
		end
		wr(BCS_DATA_ADDR, tx);
		wr(BCS_IDIS_ADDR, px);
		peer.xfer(px, 8, rx);
		ck("irq_b", 8'h01, {7'h00, irq_b});
		wr(BCS_DATA_ADDR, px);
		peer.xfer(tx, 8, rx);
		ck("irq_b", 8'h00, {7'h00, irq_b});
		wr(BCS_IDIS_ADDR, tx);
		ck("irq_b", 8'h01, {7'h00, irq_b});
		give_verdict();
	end
endmodule
`default_nettype wire
